// file: cof_map.svh
// register offsets, field positions, reset values and timing constants for the
// converter option and fault flag register bank
// assumes a 32-bit AHB-Lite slave with one register per aligned word
`ifndef COF_MAP_SVH
`define COF_MAP_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define COF_ADDR_AUX      8'h0C  // aux option config (index 3)
`define COF_ADDR_FLAGS    8'h10  // fault event flags (index 4)
`define COF_ADDR_RAMP     8'h14  // ramp rate field
`define COF_ADDR_MASK     8'h18  // interrupt mask, flag layout
`define COF_ADDR_BITS     8      // decoded address bits

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define COF_AUX_BLANK     0      // pg blank on ramp
`define COF_AUX_SINGLE    1      // standalone select
`define COF_FLG_OV        0
`define COF_FLG_UV        1
`define COF_FLG_TSHD      2
`define COF_FLG_TWRN      3
`define COF_FLG_OC        4
`define COF_FLG_HIC       5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define COF_AUX_RST       8'h00
`define COF_FLAGS_RST     8'h02
`define COF_RAMP_RST      2'h2
`define COF_MASK_RST      8'h00
`define COF_AUX_WMASK     8'h03  // writable aux bits, rest reserved
`define COF_FLAGS_WMASK   8'h3F  // live flag bits, 7:6 reserved

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define COF_CLK_MHZ       125    // device clock rate
`define COF_STEP_UV       1250   // setpoint step in microvolts
`define COF_RATE0_UV      10000  // ramp slope code 0, microvolts per microsecond
`define COF_RATE1_UV      5000   // ramp slope code 1
`define COF_RATE2_UV      1250   // ramp slope code 2
`define COF_RATE3_UV      500    // ramp slope code 3

`endif

// file: cof_pkg.sv
// types shared by the converter option and fault flag register bank
// assumes cof_map.svh holds the numeric constants
`default_nettype none
package cof_pkg;
    // raw fault event inputs from the analog side
    typedef struct packed {
        logic hiccup;     // hiccup restart
        logic overcur;    // switch current limit
        logic therm_warn; // thermal warning
        logic therm_shut; // thermal shutdown
        logic under_v;    // power bad low
        logic over_v;     // power bad high
    } cof_events_t;
    // ramp sequencer states
    typedef enum logic [1:0] {
        COF_IDLE = 2'b00,
        COF_RAMP = 2'b01,
        COF_DONE = 2'b11
    } cof_ramp_st_t;
endpackage
`default_nettype wire

// file: cof_regs.sv
// register bank: aux option config, sticky fault flags, ramp blanking
// assumes an AHB-Lite master on one 125 MHz clock; event inputs synchronous-safe
//
// How it works
// - standalone bit disables pulldown and sync output
// - blank clear: pin follows window comparator
// - blank set: pin released throughout ramp
// - aux bits 7:2 reserved, read zero
// - flag bits 7:6 reserved, read zero
// - bit 5 latches hiccup until read
// - bit 4 latches current limit until read
// - bit 3 latches thermal warning until read
// - bit 2 latches thermal shutdown until read
// - bit 1 latches undervoltage, resets to one
// - bit 0 latches overvoltage until read
// - flags at address 0x10 (index 4), reset 0x02
// - ramp rate code selects slope, blanking spans
//
// The AHB-Lite slave port was decided locally.
`include "cof_map.svh"
`default_nettype none
module cof_regs #(
    parameter int STEP_W = 8 // width of setpoint step count
) (
    input  wire logic                 i_sys_clk,       // device clock
    input  wire logic                 i_rst_b,         // async reset, low
    input  wire logic                 i_hsel,          // slave select
    input  wire logic [31:0]          i_haddr,         // byte address
    input  wire logic [1:0]           i_htrans,        // transfer type
    input  wire logic                 i_hwrite,        // write when high
    input  wire logic [2:0]           i_hsize,         // transfer size
    input  wire logic [31:0]          i_hwdata,        // write data
    input  wire logic                 i_hready,        // bus ready in
    output logic [31:0]               o_hrdata,        // read data
    output logic                      o_hreadyout,     // always ready
    output logic                      o_hresp,         // always okay
    input  wire cof_pkg::cof_events_t i_events,        // raw fault events
    input  wire logic                 i_window_ok,     // window comparator
    input  wire logic                 i_ramp_start,    // setpoint change pulse
    input  wire logic [STEP_W-1:0]    i_ramp_steps,    // steps to ramp
    output logic                      o_pg_out,        // power good level
    output logic                      o_pg_oe,         // power good drive enable
    output logic                      o_en_pulldown,   // enable pin pulldown on
    output logic                      o_sync_out_en,   // sync clock output on
    output logic                      o_ramp_active,   // ramp in progress
    output logic                      o_irq            // level interrupt
);
    // ------------------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------------------
    logic                       ph_valid;  // data phase pending
    logic                       ph_write;  // pending is a write
    logic [`COF_ADDR_BITS-1:0]  ph_addr;   // pending address
    logic                       take;      // address phase accepted
    logic [7:0]                 aux;       // aux option config
    logic [7:0]                 flags;     // sticky fault flags
    logic [7:0]                 mask;      // interrupt mask
    logic [1:0]                 ramp_rate; // ramp rate field
    logic [7:0]                 next_flags;
    logic [5:0]                 ev_s1;     // sync stage one
    logic [5:0]                 ev_s2;     // sync stage two
    logic                       rd_flags;  // flag register read now
    cof_pkg::cof_ramp_st_t      ramp_st;   // ramp state
    logic [STEP_W-1:0]          steps_left;
    logic [15:0]                tick_cnt;  // cycles into current step
    logic [15:0]                step_cycles;
    logic [7:0]                 next_rdata; // read word chosen at address phase
    logic                       wr_hit;    // write data phase hits the read word

    assign take = i_hsel & i_htrans[1] & i_hready;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // latch address phase for the data phase
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= '0;
        end else begin
            ph_valid <= take;
            ph_write <= i_hwrite;
            ph_addr  <= i_haddr[`COF_ADDR_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------------
    // data phase writes; reserved aux bits stay zero
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aux       <= `COF_AUX_RST;
            mask      <= `COF_MASK_RST;
            ramp_rate <= `COF_RAMP_RST;
        end else if (ph_valid && ph_write) begin
            case (ph_addr)
                `COF_ADDR_AUX:  aux <= i_hwdata[7:0] & `COF_AUX_WMASK;
                `COF_ADDR_MASK: mask <= i_hwdata[7:0] & `COF_FLAGS_WMASK;
                `COF_ADDR_RAMP: ramp_rate <= i_hwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // event synchroniser and sticky flags
    // ------------------------------------------------------------------------
    // two-flop sync of each event line
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ev_s1 <= '0;
            ev_s2 <= '0;
        end else begin
            ev_s1 <= i_events;
            ev_s2 <= ev_s1;
        end
    end

    // a flag read is taken at its address phase, so the read word and the
    // clear both come from the same edge
    assign rd_flags = take && !i_hwrite && (i_haddr[`COF_ADDR_BITS-1:0] == `COF_ADDR_FLAGS);

    // read clears, a new event in the same cycle wins
    always_comb begin
        next_flags = rd_flags ? 8'h00 : flags;
        next_flags = next_flags | {2'b00, ev_s2};
        next_flags = next_flags & `COF_FLAGS_WMASK;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags <= `COF_FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    assign o_irq = |(flags & mask);

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    // a read right behind a write to the same word sees the new value, so
    // back-to-back transfers need no wait state
    assign wr_hit = ph_valid && ph_write && (ph_addr == i_haddr[`COF_ADDR_BITS-1:0]);

    always_comb begin
        next_rdata = 8'h00;
        case (i_haddr[`COF_ADDR_BITS-1:0])
            `COF_ADDR_AUX:   next_rdata = wr_hit ? (i_hwdata[7:0] & `COF_AUX_WMASK) : aux;
            `COF_ADDR_FLAGS: next_rdata = flags;
            `COF_ADDR_MASK:  next_rdata = wr_hit ? (i_hwdata[7:0] & `COF_FLAGS_WMASK) : mask;
            `COF_ADDR_RAMP:  next_rdata = wr_hit ? {6'h00, i_hwdata[1:0]} : {6'h00, ramp_rate};
            default:         next_rdata = 8'h00;
        endcase
    end

    // read word loaded at the address phase, it stands through the data phase
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hrdata <= 32'h0000_0000;
        end else if (take && !i_hwrite) begin
            o_hrdata <= {24'h00_0000, next_rdata};
        end else begin
            o_hrdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // setpoint ramp sequencer
    // ------------------------------------------------------------------------
    // cycles per step: 1.25 mV step / rate (10,5,1.25,0.5 mV/us)
    always_comb begin
        case (ramp_rate)
            2'h0:    step_cycles = 16'((`COF_STEP_UV * `COF_CLK_MHZ) / `COF_RATE0_UV);
            2'h1:    step_cycles = 16'((`COF_STEP_UV * `COF_CLK_MHZ) / `COF_RATE1_UV);
            2'h2:    step_cycles = 16'((`COF_STEP_UV * `COF_CLK_MHZ) / `COF_RATE2_UV);
            default: step_cycles = 16'((`COF_STEP_UV * `COF_CLK_MHZ) / `COF_RATE3_UV);
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ramp_st    <= cof_pkg::COF_IDLE;
            steps_left <= '0;
            tick_cnt   <= 16'h0000;
        end else begin
            case (ramp_st)
                cof_pkg::COF_IDLE: begin
                    if (i_ramp_start && i_ramp_steps != '0) begin
                        ramp_st    <= cof_pkg::COF_RAMP;
                        steps_left <= i_ramp_steps;
                        tick_cnt   <= 16'h0000;
                    end
                end
                cof_pkg::COF_RAMP: begin
                    if (tick_cnt + 16'h0001 >= step_cycles) begin
                        tick_cnt <= 16'h0000;
                        if (steps_left == STEP_W'(1)) begin
                            ramp_st <= cof_pkg::COF_DONE;
                        end
                        steps_left <= steps_left - STEP_W'(1);
                    end else begin
                        tick_cnt <= tick_cnt + 16'h0001;
                    end
                end
                cof_pkg::COF_DONE: ramp_st <= cof_pkg::COF_IDLE;
                default: ramp_st <= cof_pkg::COF_IDLE;
            endcase
        end
    end

    assign o_ramp_active = (ramp_st == cof_pkg::COF_RAMP);

    // ------------------------------------------------------------------------
    // pin controls
    // ------------------------------------------------------------------------
    // power good: open drain, pulled low when output is bad
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pg_out <= 1'b0;
            o_pg_oe  <= 1'b1;
        end else begin
            o_pg_out <= 1'b0;
            if (aux[`COF_AUX_BLANK] && (ramp_st == cof_pkg::COF_RAMP ||
                    (ramp_st == cof_pkg::COF_IDLE && i_ramp_start &&
                     i_ramp_steps != '0))) begin
                o_pg_oe <= 1'b0;
            end else begin
                o_pg_oe <= !i_window_ok;
            end
        end
    end

    // standalone select turns off pulldown and sync out
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_en_pulldown <= 1'b1;
            o_sync_out_en <= 1'b1;
        end else begin
            o_en_pulldown <= !aux[`COF_AUX_SINGLE];
            o_sync_out_en <= !aux[`COF_AUX_SINGLE];
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    // clearing read with no event arriving at the same edge
    sequence s_flag_read;
        rd_flags && ev_s2 == 6'h00;
    endsequence

    a_flag_reset_val: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |-> flags == `COF_FLAGS_RST)
        else $error("flags not 0x02 after reset");
    a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        flags[7:6] == 2'b00 && aux[7:2] == 6'h00)
        else $error("reserved bits set");
    a_event_latches: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        ev_s2[`COF_FLG_HIC] |=> flags[`COF_FLG_HIC])
        else $error("hiccup not latched");
    a_read_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_flag_read |=> flags == 8'h00)
        else $error("flags not cleared by read");
    a_sync_delay: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_events.over_v && !rd_flags ##1 !rd_flags ##1 !rd_flags |=> flags[`COF_FLG_OV])
        else $error("overvoltage not latched after sync");
    a_single_pins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        aux[`COF_AUX_SINGLE] |=> !o_en_pulldown && !o_sync_out_en)
        else $error("standalone did not disable pins");
    a_pg_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !aux[`COF_AUX_BLANK] |=> o_pg_oe == !$past(i_window_ok))
        else $error("power good not following comparator");
    a_pg_blanked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        aux[`COF_AUX_BLANK] && o_ramp_active |=> !o_pg_oe)
        else $error("power good driven during ramp");
    a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !(ph_valid && ph_write) && (ev_s2 & mask[5:0]) != 6'h00 |=> o_irq)
        else $error("unmasked event did not raise interrupt");
    a_read_returns: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        rd_flags |=> o_hrdata == {24'h00_0000, $past(flags)})
        else $error("flag read returned wrong word");
    // every live flag stays set until a read clears it
    for (genvar b = 0; b < 6; b++) begin : g_sticky
        a_flag_sticky: assert property (
            @(posedge i_sys_clk) disable iff (!i_rst_b)
            flags[b] && !rd_flags |=> flags[b])
            else $error("latched flag lost without a read");
    end
    a_pins_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !aux[`COF_AUX_SINGLE] |=> o_en_pulldown && o_sync_out_en)
        else $error("pulldown or sync output off while not standalone");
    a_aux_reset: assert property (@(posedge i_sys_clk)
        $rose(i_rst_b) |-> aux == `COF_AUX_RST)
        else $error("aux config not zero after reset");
    a_ramp_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        ramp_st == cof_pkg::COF_IDLE && i_ramp_start && i_ramp_steps != '0 |=> o_ramp_active)
        else $error("setpoint ramp did not start");
endmodule
`default_nettype wire

// file: cof_regs_tb.sv
// self-checking bench for the option and fault flag register bank
// assumes cof_regs with cof_map.svh constants, single 125 MHz clock
`include "cof_map.svh"
`default_nettype none
module cof_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic                 i_sys_clk;     // device clock
    logic                 i_rst_b;       // reset, low
    logic                 hsel;          // bus select
    logic [31:0]          haddr;         // bus address
    logic [1:0]           htrans;        // transfer type
    logic                 hwrite;        // write strobe
    logic [31:0]          hwdata;        // write data
    logic [31:0]          hrdata;        // read data
    logic                 hready;        // slave ready
    logic                 hresp;         // response
    cof_pkg::cof_events_t ev;            // fault events
    logic                 win_ok;        // window comparator
    logic                 rstart;        // ramp start pulse
    logic [7:0]           rsteps;        // ramp step count
    logic                 pg_out;        // power good level
    logic                 pg_oe;         // power good drive
    logic                 en_pd;         // enable pulldown
    logic                 sync_en;       // sync output enable
    logic                 ramp_act;      // ramp running
    logic                 irq;           // interrupt
    logic [31:0]          rd_q;          // read data sampled at edge
    logic                 rdy_q;         // ready sampled at edge
    logic [31:0]          rdat;          // last read result
    int                   err_total;     // mismatches
    int                   check_count;   // comparisons
    int                   rates[4] = '{10000, 5000, 1250, 500}; // slope uV per us
    cof_regs i_dut (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_events(ev), .i_window_ok(win_ok), .i_ramp_start(rstart),
        .i_ramp_steps(rsteps), .o_pg_out(pg_out), .o_pg_oe(pg_oe),
        .o_en_pulldown(en_pd), .o_sync_out_en(sync_en), .o_ramp_active(ramp_act),
        .o_irq(irq)
    );
    // clock of 8 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // bus answer captured exactly at the edge, free of races
    always @(posedge i_sys_clk) begin
        rd_q  <= hrdata;
        rdy_q <= hready;
    end
    // ------------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one edge, then let its updates settle
    task automatic tick;
        @(posedge i_sys_clk);
        #1;
    endtask
    // wait for ready sampled high, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        tick();
        while (rdy_q !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                final_report();
            end
            tick();
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdat = rd_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h00000000);
        chk(rdat, exp);
    endtask
    // run one ramp, count its cycles, check pin drive on every ramp cycle
    task automatic ramp(input logic [1:0] code, input logic [7:0] steps, input logic oe);
        int n;
        wr(`COF_ADDR_RAMP, {30'h0, code});
        rsteps <= steps;
        rstart <= 1'b1;
        tick();
        rstart <= 1'b0;
        n = 0;
        for (int k = 0; k < 700; k++) begin
            if (ramp_act === 1'b1) begin
                n++;
                chk(pg_oe, oe);
            end
            tick();
        end
        chk(n, steps * (1250 * 125 / rates[code]));
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        check_count = 0;
        i_rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        ev = '0;
        win_ok = 1'b0;
        rstart = 1'b0;
        rsteps = 8'h00;
        repeat (20) tick();
        i_rst_b <= 1'b1;
        tick();
        chk({en_pd, sync_en, irq, hresp, ramp_act}, 32'h18);
        // unmasked undervoltage flag pending from reset raises the interrupt
        wr(`COF_ADDR_MASK, 32'h02);
        tick();
        chk(irq, 32'h1);
        rdc(`COF_ADDR_FLAGS, 32'h02);
        tick();
        chk(irq, 32'h0);
        rdc(`COF_ADDR_FLAGS, 32'h00);
        // reserved aux bits and standalone select
        rdc(`COF_ADDR_AUX, 32'h00);
        wr(`COF_ADDR_AUX, 32'h03);
        rdc(`COF_ADDR_AUX, 32'h03);
        tick();
        chk({en_pd, sync_en}, 32'h0);
        wr(`COF_ADDR_AUX, 32'h01);
        tick();
        chk({en_pd, sync_en}, 32'h3);
        // unmapped place reads zero and ignores writes
        wr(8'h1C, 32'hFF);
        rdc(8'h1C, 32'h00);
        rdc(`COF_ADDR_MASK, 32'h02);
        // each event latches its own bit, only bit 0 unmasked
        wr(`COF_ADDR_MASK, 32'h01);
        for (int b = 0; b < 6; b++) begin
            ev <= cof_pkg::cof_events_t'(6'h01 << b);
            tick();
            ev <= '0;
            repeat (4) tick();
            chk(irq, (b == 0) ? 32'h1 : 32'h0);
            rdc(`COF_ADDR_FLAGS, 32'h01 << b);
            rdc(`COF_ADDR_FLAGS, 32'h00);
        end
        // events reaching the flags at the clearing edge survive that read
        ev <= cof_pkg::cof_events_t'(6'h3F);
        tick();
        ev <= '0;
        tick();
        rdc(`COF_ADDR_FLAGS, 32'h00);
        rdc(`COF_ADDR_FLAGS, 32'h3F);
        // power good follows the window with blanking off
        wr(`COF_ADDR_AUX, 32'h00);
        win_ok <= 1'b0;
        repeat (3) tick();
        chk({pg_oe, pg_out}, 32'h2);
        win_ok <= 1'b1;
        repeat (3) tick();
        chk({pg_oe, pg_out}, 32'h0);
        // blanking releases the pin for the whole ramp
        win_ok <= 1'b0;
        wr(`COF_ADDR_AUX, 32'h01);
        ramp(2'h0, 8'h02, 1'b0);
        chk(pg_oe, 32'h1);
        wr(`COF_ADDR_AUX, 32'h00);
        for (int c = 1; c < 4; c++) begin
            ramp(c[1:0], 8'h01, 1'b1);
        end
        final_report();
    end
endmodule
`default_nettype wire
